// ==== include/ucpm_pkg.sv ====
// Package with mode codes, timing constants and carrier structs for the charge port controller.
package ucpm_pkg;

  localparam int unsigned CLK_PERIOD_PS     = 8000;
  localparam int unsigned HID_WAKE_TIME_MS  = 64;
  localparam int unsigned HID_WAKE_CYCLES   = HID_WAKE_TIME_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int unsigned DISCH_TIME_US     = 100;
  localparam int unsigned DISCH_CYCLES      = (DISCH_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned DIV2_TRIAL_US     = 1000;
  localparam int unsigned DIV2_TRIAL_CYCLES = (DIV2_TRIAL_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W             = 24;

  // Mode select code bit positions: {input_1, input_2, input_3, current_limit_select}.
  localparam int unsigned SEL_BIT_IN1 = 3;
  localparam int unsigned SEL_BIT_IN2 = 2;
  localparam int unsigned SEL_BIT_IN3 = 1;
  localparam int unsigned SEL_BIT_ILS = 0;
  localparam logic [3:0]  SEL_CDP     = 4'hF;
  localparam logic [3:0]  SEL_SPV2    = 4'hE;

  typedef enum logic [2:0] {
    UCPM_MODE_DISCHARGE,
    UCPM_MODE_AUTO,
    UCPM_MODE_STD,
    UCPM_MODE_FORCE_SHORT,
    UCPM_MODE_FORCE_DIV1,
    UCPM_MODE_CDP
  } ucpm_mode_e;

  // Line scheme presented on the connector data lines.
  typedef enum logic [2:0] {
    UCPM_LINE_OPEN,
    UCPM_LINE_PASS,
    UCPM_LINE_SHORT,
    UCPM_LINE_DIV1,
    UCPM_LINE_DIV2
  } ucpm_line_e;

  typedef struct packed {
    logic       enable;
    logic [2:0] mode_select_inputs;
    logic       current_limit_select;
  } ucpm_ctrl_s;

  typedef struct packed {
    logic dm_high;
    logic dp_primary;
    logic dp_dm_shorted;
    logic data_released;
    logic load_high;
  } ucpm_sense_s;

  typedef struct packed {
    logic       data_switch_on;
    logic       power_switch_on;
    logic       vbus_discharge;
    ucpm_line_e line_scheme;
    logic       dm_primary_resp;
    logic       hid_retained;
  } ucpm_drive_s;

endpackage : ucpm_pkg

// ==== hdl/ucpm_sync.sv ====
// Two-stage synchroniser for a group of asynchronous level inputs.
`timescale 1ns/1ps
module ucpm_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule : ucpm_sync

// ==== hdl/ucpm_ctrl.sv ====
// Charging port mode controller: mode decode, auto scheme selection, discharge and HID wake.
`timescale 1ns/1ps
// How it works
// [R1] Data switches close in standard/charging port with enable.
// [R2] Switches open on disable, all-low select, dedicated.
// [R3] Charging port keeps switches closed during handshake.
// [R4] Reset holds initial state with output discharged.
// [R5] Discharge: switch off, discharge, switch back on.
// [R6] Auto starts Divider 1; shorted device forces short.
// [R7] Shorted scheme stays until data line released.
// [R8] High load tries Divider 2, else back.
// [R9] Divider 1 low on D+, Divider 2 swapped.
// [R10] Shorted scheme bridges D+ and D-.
// [R11] Forced modes hold their scheme without switching.
// [R12] Monitor D- for low-speed HID idle high.
// [R13] HID present: ignore move to auto mode.
// [R14] HID activity starts timer; expiry enters auto.
// [R15] Host restores select before timer expires.
// [R16] Portable primary detection drives D+, samples D-.
// [R17] Portable secondary detection drives D-, samples D+.
// [R18] Charging port answers primary detection on D-.
// [R19] Mode decoded from select inputs and limit select.
// [R20] No discharge between charging and variant two.
module ucpm_ctrl #(
  parameter int unsigned HID_WAKE_CNT   = ucpm_pkg::HID_WAKE_CYCLES,
  parameter int unsigned DISCH_CNT      = ucpm_pkg::DISCH_CYCLES,
  parameter int unsigned DIV2_TRIAL_CNT = ucpm_pkg::DIV2_TRIAL_CYCLES
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  sys_rst_i,
  input  wire ucpm_pkg::ucpm_ctrl_s  ctrl_i,
  input  wire ucpm_pkg::ucpm_sense_s sense_i,
  output ucpm_pkg::ucpm_drive_s      drive_o
);
  import ucpm_pkg::*;

  function automatic ucpm_mode_e decode_mode(input logic [3:0] sel);
    unique casez (sel)
      4'b000?: decode_mode = UCPM_MODE_DISCHARGE;
      4'b001?: decode_mode = UCPM_MODE_AUTO;
      4'b011?: decode_mode = UCPM_MODE_AUTO;
      4'b010?: decode_mode = UCPM_MODE_STD;
      4'b110?: decode_mode = UCPM_MODE_STD;
      4'b1110: decode_mode = UCPM_MODE_STD;
      4'b100?: decode_mode = UCPM_MODE_FORCE_SHORT;
      4'b101?: decode_mode = UCPM_MODE_FORCE_DIV1;
      4'b1111: decode_mode = UCPM_MODE_CDP;
      default: decode_mode = UCPM_MODE_DISCHARGE;
    endcase
  endfunction : decode_mode

  typedef enum {ST_INIT, ST_DISCH, ST_RUN} ucpm_state_e;

  ucpm_ctrl_s  ctrl_s;
  ucpm_sense_s sense_s;
  ucpm_state_e state;
  ucpm_state_e next_state;
  ucpm_mode_e  mode;
  ucpm_mode_e  next_mode;
  ucpm_line_e  auto_line;
  ucpm_line_e  next_auto_line;
  logic [3:0]  sel_prev;
  logic [CNT_W-1:0] disch_cnt;
  logic [CNT_W-1:0] trial_cnt;
  logic [CNT_W-1:0] hid_cnt;
  logic        hid_seen;
  logic        hid_hold;
  logic        hid_timing;
  logic        dm_prev;
  ucpm_drive_s next_drive;

  ucpm_sync #(
    .WIDTH($bits(ucpm_ctrl_s) + $bits(ucpm_sense_s))
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({ctrl_i, sense_i}),
    .sync_o    ({ctrl_s, sense_s})
  );

  wire logic [3:0] sel_code   = {ctrl_s.mode_select_inputs, ctrl_s.current_limit_select};
  wire ucpm_mode_e req_mode   = decode_mode(sel_code); // [R19]
  wire logic       sel_change = (sel_code != sel_prev);
  wire logic       cdp_spv2_swap = ({sel_code[3:1], 1'b0} == SEL_SPV2)
                                 && ({sel_prev[3:1], 1'b0} == SEL_SPV2); // [R20]
  wire logic       data_mode  = (mode == UCPM_MODE_CDP) || (mode == UCPM_MODE_STD);
  wire logic       hid_block  = hid_seen && data_mode && (req_mode == UCPM_MODE_AUTO); // [R13]
  wire ucpm_mode_e eff_req    = hid_block ? mode : req_mode;
  wire logic       stop_req   = !ctrl_s.enable || (req_mode == UCPM_MODE_DISCHARGE); // [R2]
  wire logic       need_disch = sel_change && !cdp_spv2_swap && (eff_req != mode);
  wire logic       disch_done = (disch_cnt >= CNT_W'(DISCH_CNT - 1));
  wire logic       trial_done = (trial_cnt >= CNT_W'(DIV2_TRIAL_CNT - 1));
  wire logic       hid_expire = hid_timing && (hid_cnt >= CNT_W'(HID_WAKE_CNT - 1));
  wire logic       short_seen = sense_s.dp_dm_shorted && (auto_line != UCPM_LINE_SHORT);
  wire logic       run_sel_switch = sel_change && (eff_req != mode) && !need_disch;

  always_comb begin
    next_state     = state;
    next_mode      = mode;
    next_auto_line = auto_line;
    unique case (state)
      ST_INIT: begin
        next_mode  = req_mode; // [R4]
        next_state = stop_req ? ST_INIT : ST_DISCH;
        next_auto_line = UCPM_LINE_DIV1;
      end
      ST_DISCH: begin
        // A select change during the discharge is followed, so the run starts in the new mode.
        next_mode = eff_req;
        if (disch_done) begin
          next_state = stop_req ? ST_INIT : ST_RUN; // [R5]
        end
      end
      ST_RUN: begin
        if (stop_req) begin
          next_state = ST_INIT;
        end else if (hid_expire && req_mode == UCPM_MODE_AUTO) begin
          next_mode      = UCPM_MODE_AUTO; // [R14]
          next_auto_line = UCPM_LINE_DIV1;
          next_state     = ST_DISCH;
        end else if (need_disch) begin
          next_mode      = eff_req;
          next_auto_line = UCPM_LINE_DIV1; // [R6]
          next_state     = ST_DISCH;
        end else if (run_sel_switch) begin
          next_mode = eff_req;
        end else if (mode == UCPM_MODE_AUTO) begin
          if (short_seen) begin
            next_auto_line = UCPM_LINE_SHORT; // [R6]
            next_state     = ST_DISCH;
          end else if (auto_line == UCPM_LINE_SHORT && sense_s.data_released) begin
            next_auto_line = UCPM_LINE_DIV1; // [R7]
          end else if (auto_line == UCPM_LINE_DIV1 && sense_s.load_high) begin
            next_auto_line = UCPM_LINE_DIV2; // [R8]
          end else if (auto_line == UCPM_LINE_DIV2 && trial_done && !sense_s.load_high) begin
            next_auto_line = UCPM_LINE_DIV1; // [R8]
          end
        end
      end
    endcase
  end

  always_comb begin
    next_drive                 = '0;
    next_drive.line_scheme     = UCPM_LINE_OPEN;
    next_drive.hid_retained    = hid_block && (next_state == ST_RUN); // [R13]
    next_drive.power_switch_on = (next_state == ST_RUN); // [R5]
    next_drive.vbus_discharge  = (next_state != ST_RUN); // [R4]
    if (next_state == ST_RUN) begin
      unique case (next_mode)
        UCPM_MODE_STD, UCPM_MODE_CDP: begin
          next_drive.line_scheme    = UCPM_LINE_PASS;
          next_drive.data_switch_on = ctrl_s.enable; // [R1] [R2] [R3]
          next_drive.dm_primary_resp = (next_mode == UCPM_MODE_CDP)
                                     && sense_s.dp_primary; // [R18]
        end
        UCPM_MODE_FORCE_SHORT: next_drive.line_scheme = UCPM_LINE_SHORT; // [R10] [R11]
        UCPM_MODE_FORCE_DIV1:  next_drive.line_scheme = UCPM_LINE_DIV1; // [R9] [R11]
        UCPM_MODE_AUTO:        next_drive.line_scheme = next_auto_line; // [R9]
        UCPM_MODE_DISCHARGE:   next_drive.line_scheme = UCPM_LINE_OPEN; // [R2]
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state     <= ST_INIT;
      mode      <= UCPM_MODE_DISCHARGE;
      auto_line <= UCPM_LINE_DIV1;
      sel_prev  <= '0;
      drive_o   <= '{default: '0, line_scheme: UCPM_LINE_OPEN, vbus_discharge: 1'b1};
    end else begin
      state     <= next_state;
      mode      <= next_mode;
      auto_line <= next_auto_line;
      sel_prev  <= sel_code;
      drive_o   <= next_drive;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || state != ST_DISCH) begin
      disch_cnt <= '0;
    end else begin
      disch_cnt <= disch_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || auto_line != UCPM_LINE_DIV2) begin
      trial_cnt <= '0;
    end else if (!trial_done) begin
      trial_cnt <= trial_cnt + 1'b1;
    end
  end

  // Low-speed HID idles with D- high; a low pulse while retained starts the wake timer.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      hid_seen   <= 1'b0;
      hid_hold   <= 1'b0;
      hid_timing <= 1'b0;
      hid_cnt    <= '0;
      dm_prev    <= 1'b0;
    end else begin
      dm_prev  <= sense_s.dm_high;
      hid_hold <= hid_block;
      if (!data_mode || state != ST_RUN) begin
        hid_seen <= 1'b0;
      end else if (sense_s.dm_high && !hid_block) begin
        hid_seen <= 1'b1; // [R12]
      end
      if (!hid_block) begin
        hid_timing <= 1'b0;
        hid_cnt    <= '0;
      end else if (hid_hold && dm_prev && !sense_s.dm_high && !hid_timing) begin
        hid_timing <= 1'b1; // [R14]
        hid_cnt    <= '0;
      end else if (hid_timing && !hid_expire) begin
        hid_cnt <= hid_cnt + 1'b1; // [R14]
      end
    end
  end

endmodule : ucpm_ctrl

// ==== test/ucpm_ctrl_chk.sv ====
// Checker with port-level assertions for the charge port controller.
`timescale 1ns/1ps
module ucpm_ctrl_chk (
  input  wire logic                  clk_sys_i,
  input  wire logic                  sys_rst_i,
  input  wire ucpm_pkg::ucpm_ctrl_s  ctrl_i,
  input  wire ucpm_pkg::ucpm_sense_s sense_i,
  input  wire ucpm_pkg::ucpm_drive_s drive_o
);
  import ucpm_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  wire logic off_req = !ctrl_i.enable || ctrl_i.mode_select_inputs == 3'b000;
  wire logic sh_req  = ctrl_i.enable && ctrl_i.mode_select_inputs == 3'b100;
  wire logic d1_req  = ctrl_i.enable && ctrl_i.mode_select_inputs == 3'b101;
  wire logic cp_req  = ctrl_i.enable && ctrl_i.mode_select_inputs == 3'b111;
  a_reset_state: assert property (disable iff (1'b0) sys_rst_i |=>
    drive_o.vbus_discharge && !drive_o.power_switch_on && !drive_o.data_switch_on)
    else $error("outputs not in initial state after reset");
  a_off_opens: assert property (off_req [*6] |->
    !drive_o.data_switch_on && !drive_o.power_switch_on)
    else $error("switches on while disabled or select all low");
  a_switch_pass_only: assert property (drive_o.data_switch_on |->
    drive_o.line_scheme == UCPM_LINE_PASS && drive_o.power_switch_on)
    else $error("data switch on outside a data mode");
  a_disch_power_off: assert property (drive_o.vbus_discharge |-> !drive_o.power_switch_on)
    else $error("discharge while power switch on");
  a_forced_short: assert property (sh_req [*6] ##0 drive_o.power_switch_on |->
    drive_o.line_scheme == UCPM_LINE_SHORT)
    else $error("forced shorted scheme not held");
  a_forced_div1: assert property (d1_req [*6] ##0 drive_o.power_switch_on |->
    drive_o.line_scheme == UCPM_LINE_DIV1)
    else $error("forced divider scheme not held");
  a_cdp_no_disch: assert property (cp_req [*6] ##0 drive_o.power_switch_on |=>
    drive_o.power_switch_on)
    else $error("power dropped between charging and variant two");
  a_hid_keeps_data: assert property (drive_o.hid_retained |-> drive_o.data_switch_on)
    else $error("retained HID lost its data path");
  a_resp_in_data: assert property (drive_o.dm_primary_resp |-> drive_o.data_switch_on)
    else $error("detect answer without data path");
  c_div2: cover property (drive_o.line_scheme == UCPM_LINE_DIV2);
  c_short: cover property (drive_o.line_scheme == UCPM_LINE_SHORT);
  c_hid: cover property (drive_o.hid_retained);
  c_resp: cover property (drive_o.dm_primary_resp);
endmodule : ucpm_ctrl_chk
bind ucpm_ctrl ucpm_ctrl_chk u_ucpm_ctrl_chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
  .ctrl_i(ctrl_i), .sense_i(sense_i), .drive_o(drive_o));

// ==== test/ucpm_portable.sv ====
// Behavioural portable device on the far side of the charge port.
`timescale 1ns/1ps
module ucpm_portable (
  input  wire logic                  hid_i,
  input  wire logic                  click_i,
  input  wire logic                  shorts_i,
  input  wire logic                  heavy_i,
  input  wire logic                  detect_i,
  input  wire ucpm_pkg::ucpm_drive_s drive_i,
  output ucpm_pkg::ucpm_sense_s      sense_o,
  output logic                       charging_port_o,
  output logic                       secondary_cdp_o
);
  import ucpm_pkg::*;
  // A low-speed HID idles with D- high and pulls it low while clicked.
  assign sense_o.dm_high       = hid_i && !click_i;
  assign sense_o.dp_primary    = detect_i && drive_i.data_switch_on;
  assign sense_o.dp_dm_shorted = shorts_i;
  assign sense_o.data_released = !shorts_i;
  assign sense_o.load_high     = heavy_i && drive_i.power_switch_on;
  assign charging_port_o       = sense_o.dp_primary && drive_i.dm_primary_resp;
  // Secondary detection drives D- and reads D+, which only a shorted scheme would lift.
  assign secondary_cdp_o = charging_port_o && (drive_i.line_scheme != UCPM_LINE_SHORT);
endmodule : ucpm_portable

// ==== test/ucpm_ctrl_bench.sv ====
// Self-checking testbench for the charge port controller.
`timescale 1ns/1ps
module ucpm_ctrl_bench;
  import ucpm_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  ucpm_ctrl_s  ctrl = '0;
  ucpm_sense_s sense;
  ucpm_drive_s drv;
  logic        hid = 1'b0;
  logic        click = 1'b0;
  logic        shorts = 1'b0;
  logic        heavy = 1'b0;
  logic        detect = 1'b0;
  logic        chg;
  logic        cdp;
  int          miscompares = 0;
  int          checked = 0;
  initial forever #4 clk_sys_i = ~clk_sys_i;
  ucpm_ctrl #(.HID_WAKE_CNT(50), .DISCH_CNT(8), .DIV2_TRIAL_CNT(20)) u_ucpm_ctrl (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ctrl_i(ctrl), .sense_i(sense),
    .drive_o(drv));
  ucpm_portable u_ucpm_portable (.hid_i(hid), .click_i(click), .shorts_i(shorts),
    .heavy_i(heavy), .detect_i(detect), .drive_i(drv), .sense_o(sense),
    .charging_port_o(chg), .secondary_cdp_o(cdp));
  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  task automatic cmp_bit(string what, logic exp, logic got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit
  task automatic cmp_line(ucpm_line_e exp);
    checked++;
    if (drv.line_scheme !== exp) begin
      miscompares++;
      $display("ERROR line_scheme expected %0d seen %0d", exp, drv.line_scheme);
    end
  endtask : cmp_line
  task automatic step(int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask : step
  task automatic put(logic en, logic [3:0] code);
    ctrl = '{enable: en, mode_select_inputs: code[3:1], current_limit_select: code[0]};
  endtask : put
  // Waits for the scheme to settle with the power switch on.
  task automatic wait_line(ucpm_line_e exp);
    int n;
    n = 0;
    while (!(drv.line_scheme === exp && drv.power_switch_on === 1'b1) && n < 200) begin
      step(1);
      n++;
    end
    cmp_line(exp);
    cmp_bit("power_switch_on", 1'b1, drv.power_switch_on);
    if (n == 200) final_report();
  endtask : wait_line
  task automatic t_cdp();
    put(1'b1, 4'hF);
    wait_line(UCPM_LINE_PASS);
    cmp_bit("data_switch_on", 1'b1, drv.data_switch_on);
    cmp_bit("charging_port", 1'b0, chg);
    detect = 1'b1;
    step(6);
    cmp_bit("charging_port", 1'b1, chg);
    cmp_bit("secondary_cdp", 1'b1, cdp);
    cmp_bit("data_switch_on", 1'b1, drv.data_switch_on);
    detect = 1'b0;
    put(1'b1, 4'hE);
    repeat (12) begin
      step(1);
      cmp_bit("power_switch_on", 1'b1, drv.power_switch_on);
    end
  endtask : t_cdp
  task automatic t_off();
    put(1'b1, 4'h1);
    step(6);
    cmp_bit("data_switch_on", 1'b0, drv.data_switch_on);
    cmp_bit("vbus_discharge", 1'b1, drv.vbus_discharge);
    put(1'b1, 4'hE);
    wait_line(UCPM_LINE_PASS);
    put(1'b0, 4'hE);
    step(6);
    cmp_bit("data_switch_on", 1'b0, drv.data_switch_on);
    cmp_bit("power_switch_on", 1'b0, drv.power_switch_on);
  endtask : t_off
  task automatic t_auto();
    put(1'b1, 4'h2);
    wait_line(UCPM_LINE_DIV1);
    heavy = 1'b1;
    wait_line(UCPM_LINE_DIV2);
    step(40);
    cmp_line(UCPM_LINE_DIV2);
    heavy = 1'b0;
    wait_line(UCPM_LINE_DIV1);
    shorts = 1'b1;
    step(5);
    cmp_bit("vbus_discharge", 1'b1, drv.vbus_discharge);
    wait_line(UCPM_LINE_SHORT);
    shorts = 1'b0;
    wait_line(UCPM_LINE_DIV1);
  endtask : t_auto
  task automatic t_forced();
    put(1'b1, 4'h8);
    wait_line(UCPM_LINE_SHORT);
    cmp_bit("data_switch_on", 1'b0, drv.data_switch_on);
    heavy = 1'b1;
    step(40);
    cmp_line(UCPM_LINE_SHORT);
    put(1'b1, 4'hB);
    wait_line(UCPM_LINE_DIV1);
    step(40);
    cmp_line(UCPM_LINE_DIV1);
    heavy = 1'b0;
  endtask : t_forced
  // A reset in mid-run must drop to the discharged initial state and then resume the mode.
  task automatic t_reset();
    sys_rst_i = 1'b1;
    step(3);
    cmp_bit("vbus_discharge", 1'b1, drv.vbus_discharge);
    cmp_bit("power_switch_on", 1'b0, drv.power_switch_on);
    cmp_line(UCPM_LINE_OPEN);
    sys_rst_i = 1'b0;
    wait_line(UCPM_LINE_DIV1);
  endtask : t_reset
  task automatic t_hid();
    put(1'b1, 4'h4);
    wait_line(UCPM_LINE_PASS);
    put(1'b1, 4'h6);
    wait_line(UCPM_LINE_DIV1);
    hid = 1'b1;
    put(1'b1, 4'h4);
    wait_line(UCPM_LINE_PASS);
    put(1'b1, 4'h6);
    step(20);
    cmp_line(UCPM_LINE_PASS);
    cmp_bit("hid_retained", 1'b1, drv.hid_retained);
    click = 1'b1;
    step(3);
    click = 1'b0;
    put(1'b1, 4'h4);
    repeat (60) begin
      step(1);
      cmp_bit("power_switch_on", 1'b1, drv.power_switch_on);
    end
    cmp_bit("hid_retained", 1'b0, drv.hid_retained);
    put(1'b1, 4'h6);
    step(20);
    cmp_bit("hid_retained", 1'b1, drv.hid_retained);
    click = 1'b1;
    step(3);
    click = 1'b0;
    step(30);
    cmp_line(UCPM_LINE_PASS);
    wait_line(UCPM_LINE_DIV1);
  endtask : t_hid
  initial begin
    step(20);
    cmp_bit("vbus_discharge", 1'b1, drv.vbus_discharge);
    sys_rst_i = 1'b0;
    t_cdp();
    t_off();
    t_auto();
    t_forced();
    t_reset();
    t_hid();
    final_report();
  end
endmodule : ucpm_ctrl_bench
